/* clock_select_defines.svh */
// Register offsets, field positions and reset values of the clock select block.
// Assumes an APB slave with 32-bit data and byte addresses.
`ifndef CLOCK_SELECT_DEFINES_SVH
`define CLOCK_SELECT_DEFINES_SVH
`define CSS_OFFSET 8'h00
`define OSC_CTRL_OFFSET 8'h04
`define CLK_STATUS_OFFSET 8'h08
`define CSS_USB_MSB 5
`define CSS_USB_LSB 4
`define CSS_SYS_MSB 2
`define CSS_SYS_LSB 0
`define CSS_RESET 8'h00
`define OSC_DIV_MSB 1
`define OSC_DIV_LSB 0
`define OSC_MULTIPLIER_INPUT_SELECT_BIT 8
`define OSC_DIV_RESET 2'h0
`define OSC_MULTIPLIER_INPUT_SELECT_RESET 1'h0
`define STAT_USB_LSB 4
`define STAT_SYS_LSB 0
`define STAT_USB_BUSY_BIT 8
`define STAT_SYS_BUSY_BIT 9
`endif

/* clock_select_pkg.sv */
// Types shared by the clock select block.
// Assumes nothing of its surroundings.
package clock_select_pkg;
  typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} switch_state_t;
  typedef logic [1:0] src_code_t;
endpackage

/* usb_and_system_clock_select.sv */
// USB and system clock source selection with an APB register file.
// Assumes clock sources arrive as asynchronous levels oversampled by pclk at 100 MHz.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "clock_select_defines.svh"

module glitch_free_switch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] src,
  input wire clock_select_pkg::src_code_t req,
  output logic clk_out,
  output clock_select_pkg::src_code_t cur,
  output logic busy
);
  import clock_select_pkg::*;

  switch_state_t state_r, state_nxt;
  src_code_t cur_r, cur_nxt;
  logic out_r, out_nxt;

  // The old source is left only while it is low, and the new one is joined only
  // at a low phase, so no shortened high can appear.
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    out_nxt = 1'b0;
    unique case (state_r)
      SW_RUN: begin
        out_nxt = src[cur_r];
        if (req != cur_r) begin
          state_nxt = SW_DRAIN;
        end
      end
      SW_DRAIN: begin
        out_nxt = src[cur_r];
        if (!src[cur_r]) begin
          out_nxt = 1'b0;
          cur_nxt = req;
          state_nxt = SW_ARM;
        end
      end
      SW_ARM: begin
        if (!src[cur_r]) begin
          state_nxt = SW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SW_RUN;
      cur_r <= 2'h0;
      out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;
  assign cur = cur_r;
  assign busy = (state_r != SW_RUN);
endmodule

module usb_and_system_clock_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_osc_clk,
  input wire logic ext_clk,
  input wire logic mult_clk,
  input wire logic lf_osc_clk,
  output logic usb_clk_out,
  output logic sys_clk_out,
  output logic mult_ref_clk
);
  import clock_select_pkg::*;

  localparam int NSRC = 4;

  // Source order in the synchroniser bank: internal, external, multiplier, low-freq.
  logic [NSRC-1:0] raw_src;
  logic [NSRC-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  assign raw_src = {lf_osc_clk, mult_clk, ext_clk, int_osc_clk};

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_sync
      always_comb begin
        filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          filt_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= raw_src[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          filt_r[g] <= filt_nxt[g];
        end
      end
    end
  endgenerate

  logic int_f, ext_f, mult_f, lf_f;
  assign int_f = filt_r[0];
  assign ext_f = filt_r[1];
  assign mult_f = filt_r[2];
  assign lf_f = filt_r[3];

  // Dividers count rising edges of the filtered sources.
  logic int_d_r, mult_d_r;
  logic [2:0] int_cnt_r, int_cnt_nxt;
  logic mult_half_r, mult_half_nxt;
  always_comb begin
    int_cnt_nxt = int_cnt_r;
    mult_half_nxt = mult_half_r;
    if (int_f && !int_d_r) begin
      int_cnt_nxt = int_cnt_r + 3'h1;
    end
    if (mult_f && !mult_d_r) begin
      mult_half_nxt = !mult_half_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_d_r <= 1'b0;
      mult_d_r <= 1'b0;
      int_cnt_r <= 3'h0;
      mult_half_r <= 1'b0;
    end else begin
      int_d_r <= int_f;
      mult_d_r <= mult_f;
      int_cnt_r <= int_cnt_nxt;
      mult_half_r <= mult_half_nxt;
    end
  end

  // Register file.
  logic [7:0] css_r, css_nxt;
  logic [1:0] osc_div_r, osc_div_nxt;
  logic multiplier_input_select_r, multiplier_input_select_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] rd_word;
  logic hit;
  logic usb_busy, sys_busy;
  src_code_t usb_cur, sys_cur;

  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `CSS_OFFSET: rd_word = {24'h00_0000, css_r};
      `OSC_CTRL_OFFSET: begin
        rd_word[`OSC_DIV_MSB:`OSC_DIV_LSB] = osc_div_r;
        rd_word[`OSC_MULTIPLIER_INPUT_SELECT_BIT] = multiplier_input_select_r;
      end
      `CLK_STATUS_OFFSET: begin
        rd_word[`STAT_USB_LSB +: 2] = usb_cur;
        rd_word[`STAT_SYS_LSB +: 2] = sys_cur;
        rd_word[`STAT_USB_BUSY_BIT] = usb_busy;
        rd_word[`STAT_SYS_BUSY_BIT] = sys_busy;
      end
      default: hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle, where the write lands.
  always_comb begin
    css_nxt = css_r;
    osc_div_nxt = osc_div_r;
    multiplier_input_select_nxt = multiplier_input_select_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !hit;
      prdata_nxt = pwrite ? 32'h0000_0000 : rd_word;
    end
    if (psel && penable && pready_r && pwrite && !pslverr_r) begin
      if (paddr == `CSS_OFFSET && pstrb[0]) begin
        css_nxt[`CSS_USB_MSB:`CSS_USB_LSB] = pwdata[`CSS_USB_MSB:`CSS_USB_LSB];
        // Reserved system codes are refused so the system mux never sees one.
        if (!pwdata[`CSS_SYS_MSB]) begin
          css_nxt[`CSS_SYS_MSB:`CSS_SYS_LSB] = pwdata[`CSS_SYS_MSB:`CSS_SYS_LSB];
        end
      end
      if (paddr == `OSC_CTRL_OFFSET) begin
        if (pstrb[0]) begin
          osc_div_nxt = pwdata[`OSC_DIV_MSB:`OSC_DIV_LSB];
        end
        if (pstrb[1]) begin
          multiplier_input_select_nxt = pwdata[`OSC_MULTIPLIER_INPUT_SELECT_BIT];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      css_r <= `CSS_RESET;
      osc_div_r <= `OSC_DIV_RESET;
      multiplier_input_select_r <= `OSC_MULTIPLIER_INPUT_SELECT_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      css_r <= css_nxt;
      osc_div_r <= osc_div_nxt;
      multiplier_input_select_r <= multiplier_input_select_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // The applied divide follows the register only while every divided copy of the
  // internal source is low, so a new divide setting never cuts a high phase short.
  logic [1:0] div_act_r, div_act_nxt;
  always_comb begin
    div_act_nxt = div_act_r;
    if (int_cnt_r == 3'h0 && !int_f) begin
      div_act_nxt = osc_div_r;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_act_r <= `OSC_DIV_RESET;
    end else begin
      div_act_r <= div_act_nxt;
    end
  end

  // Candidate sources for each mux, indexed by the select code.
  logic int_sys_src;
  logic [3:0] usb_src, sys_src;
  always_comb begin
    unique case (div_act_r)
      2'h0: int_sys_src = int_cnt_r[2];
      2'h1: int_sys_src = int_cnt_r[1];
      2'h2: int_sys_src = int_cnt_r[0];
      2'h3: int_sys_src = int_f;
    endcase
    usb_src = {1'b0, ext_f, int_cnt_r[0], mult_f};
    sys_src = {lf_f, mult_half_r, ext_f, int_sys_src};
  end

  glitch_free_switch u_usb_switch (
    .pclk(pclk),
    .presetn(presetn),
    .src(usb_src),
    .req(css_r[`CSS_USB_MSB:`CSS_USB_LSB]),
    .clk_out(usb_clk_out),
    .cur(usb_cur),
    .busy(usb_busy)
  );

  glitch_free_switch u_sys_switch (
    .pclk(pclk),
    .presetn(presetn),
    .src(sys_src),
    .req(css_r[1:0]),
    .clk_out(sys_clk_out),
    .cur(sys_cur),
    .busy(sys_busy)
  );

  logic mref_r, mref_nxt;
  always_comb begin
    mref_nxt = multiplier_input_select_r ? ext_f : int_f;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mref_r <= 1'b0;
    end else begin
      mref_r <= mref_nxt;
    end
  end

  assign mult_ref_clk = mref_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_usb_off_low: assert property (usb_cur == 2'h3 && !usb_busy |-> !usb_clk_out)
    else $error("USB clock toggles while off");
  a_usb_route_mux: assert property (!usb_busy && $past(!usb_busy) |-> usb_clk_out == $past(usb_src[usb_cur]))
    else $error("USB clock not from selected source");
  a_sys_no_reserved: assert property (!css_r[`CSS_SYS_MSB])
    else $error("Reserved system code stored");
  a_unused_bits_zero: assert property (css_r[7:6] == 2'h0 && !css_r[3])
    else $error("Unused select bits nonzero");
  a_div_one_path: assert property (div_act_r == 2'h3 && $past(div_act_r) == 2'h3
    && sys_cur == 2'h0 && !sys_busy && $past(!sys_busy) |-> sys_clk_out == $past(int_f))
    else $error("Divide-by-one path wrong");
  a_mult_ref_sel: assert property (##1 mult_ref_clk == $past(multiplier_input_select_r ? ext_f : int_f))
    else $error("Multiplier reference wrong");
  a_usb_switch_low: assert property ($changed(usb_cur) |-> !usb_clk_out ##1 !usb_clk_out)
    else $error("USB clock high across switch");
  a_sys_switch_low: assert property ($changed(sys_cur) |-> !sys_clk_out)
    else $error("System clock high across switch");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("APB answer late");

  c_usb_switch: cover property ($fell(usb_busy));
  c_sys_switch: cover property ($fell(sys_busy));
  c_usb_off: cover property (usb_cur == 2'h3 && !usb_busy);
  c_apb_error: cover property (pready && pslverr);
endmodule

/* usb_and_system_clock_select_tb.sv */
// Self-checking bench for the clock select block: a register model and edge counting.
// Assumes source clocks far slower than pclk; the bus task waits for pready for at most 20 cycles.
`timescale 1ns/1ps
module usb_and_system_clock_select_tb;
  localparam int W = 960;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, rd;
  logic [31:0] seed = 32'h1945;
  logic pready, pslverr, err, usb_clk_out, sys_clk_out, mult_ref_clk;
  logic int_osc_clk = 1'b0;
  logic ext_clk = 1'b0;
  logic mult_clk = 1'b0;
  logic lf_osc_clk = 1'b0;
  logic [2:0] prv;
  logic [7:0] sel_m = 8'h00;
  logic [31:0] osc_m = 32'h0;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int runt = 0;
  int hu = 0;
  int hs = 0;
  int nu, ns, nm;
  int usb_p[4] = '{12, 32, 24, 0};
  int sys_p[4] = '{16, 24, 24, 40};

  usb_and_system_clock_select usb_and_system_clock_select_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .int_osc_clk, .ext_clk, .mult_clk, .lf_osc_clk,
    .usb_clk_out, .sys_clk_out, .mult_ref_clk);

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    int_osc_clk <= (cyc % 16) < 8;
    ext_clk <= (cyc % 24) < 12;
    mult_clk <= (cyc % 12) < 6;
    lf_osc_clk <= (cyc % 40) < 20;
  end

  // A high phase shorter than 4 cycles is a runt left by a switch.
  always @(posedge pclk) begin
    hu <= usb_clk_out ? hu + 1 : 0;
    hs <= sys_clk_out ? hs + 1 : 0;
    if ((!usb_clk_out && hu > 0 && hu < 4) || (!sys_clk_out && hs > 0 && hs < 4)) begin
      runt <= runt + 1;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Edge counts may differ by one because the window start is not aligned to a source phase.
  task automatic check_cnt(input int got, input int exp);
    check_count++;
    if (got > exp + 1 || got < exp - 1) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? st : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    apb(1'b1, a, d, st);
    check_reg({31'h0, err}, {31'h0, a > 8'h08});
    if (a == 8'h00 && st[0]) sel_m = {2'b00, d[5:4], 1'b0, d[2] ? sel_m[2:0] : d[2:0]};
    if (a == 8'h04 && st[0]) osc_m[1:0] = d[1:0];
    if (a == 8'h04 && st[1]) osc_m[8] = d[8];
  endtask

  task automatic measure();
    nu = 0;
    ns = 0;
    nm = 0;
    // A divide change waits for every divided copy of the internal source to be low, up to 128 cycles.
    repeat (160) @(posedge pclk);
    prv = {usb_clk_out, sys_clk_out, mult_ref_clk};
    repeat (W) begin
      @(posedge pclk);
      nu += int'(usb_clk_out & !prv[2]);
      ns += int'(sys_clk_out & !prv[1]);
      nm += int'(mult_ref_clk & !prv[0]);
      prv = {usb_clk_out, sys_clk_out, mult_ref_clk};
    end
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    check_reg(rd, 32'h0);
    wr(8'h00, 32'h0000_00FF, 4'hF);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    check_reg(rd, {24'h0, sel_m});
    repeat (12) begin
      seed = lfsr(seed);
      wr({4'h0, seed[3:2], 2'b00}, seed, seed[11:8]);
      apb(1'b0, 8'h00, 32'h0, 4'h0);
      check_reg(rd, {24'h0, sel_m});
      apb(1'b0, 8'h04, 32'h0, 4'h0);
      check_reg(rd, osc_m);
    end
    apb(1'b0, 8'h0C, 32'h0, 4'h0);
    check_reg({rd[30:0], err}, 32'h1);
    wr(8'h04, 32'h0000_0003, 4'hF);
    for (int u = 0; u < 4; u++) begin
      for (int s = 0; s < 4; s++) begin
        wr(8'h00, 32'(u * 16 + s), 4'hF);
        measure();
        check_cnt(nu, usb_p[u] > 0 ? W / usb_p[u] : 0);
        check_cnt(ns, W / sys_p[s]);
        apb(1'b0, 8'h08, 32'h0, 4'h0);
        check_reg(rd, 32'(u * 16 + s));
      end
    end
    wr(8'h00, 32'h0, 4'hF);
    for (int d = 0; d < 4; d++) begin
      wr(8'h04, 32'(d % 2 * 256 + d), 4'hF);
      measure();
      check_cnt(ns, W / (16 * (8 >> d)));
      check_cnt(nm, W / (d % 2 == 1 ? 24 : 16));
    end
    check_reg(32'(runt), 32'h0);
    final_report();
  end
endmodule
